// file: sbt_assertions.sv
// concurrent checks on the ports of the store-back and test-branch block
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_top_chk (
  input wire logic                  mclk,
  input wire logic                  srst,
  input wire logic                  order_valid,
  input wire logic                  order_ready,
  input wire logic                  order_halt,
  input wire logic                  main_done,
  input wire logic                  continue_press,
  input wire logic [`SBT_IDX_W-1:0] control_counter,
  input wire logic [`SBT_IDX_W-1:0] held_addr,
  input wire logic                  order_done,
  input wire logic                  halted
);
  // ==========================================================
  // order sequencing
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_DONE_IDLE: assert property (order_done |-> order_ready)
    else $error("order_done while not idle");
  AST_DONE_PULSE: assert property (order_done |=> !order_done)
    else $error("order_done longer than one cycle");
  AST_TAKE_BUSY: assert property (order_valid && order_ready && !order_halt
    |=> !order_ready ##1 !order_ready) else $error("ready too early after take");
  AST_MAIN_LAT: assert property ((order_valid && order_ready && !order_halt)
    ##1 main_done |=> !order_done ##1 order_done) else $error("done latency wrong");
  AST_MAIN_WAIT: assert property ((order_valid && order_ready && !order_halt)
    ##1 !main_done |=> !order_done [*2]) else $error("done before main stage");
  AST_HALT_ENTER: assert property (order_valid && order_ready && order_halt
    |=> halted) else $error("halt order did not stop");
  AST_HALT_HOLD: assert property (halted && !continue_press
    |=> halted && $stable(held_addr)) else $error("halt not held");
  AST_HALT_GO: assert property (halted && continue_press |=> !halted && order_done
    && control_counter == $past(control_counter) + 15'h0001) else $error("bad resume");
  AST_HALT_BUSY: assert property (halted |-> !order_ready)
    else $error("order accepted while halted");
  // the counter only moves at an order end
  AST_CC_STABLE: assert property (!order_done && !$past(srst)
    |-> $stable(control_counter)) else $error("counter moved between orders");
endmodule : sbt_top_chk

bind sbt_top sbt_top_chk chk_u (.mclk, .srst, .order_valid, .order_ready, .order_halt,
  .main_done, .continue_press, .control_counter, .held_addr, .order_done, .halted);

// file: sbt_consts.svh
// constants for the store-back and test-branch block
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH

`define SBT_WORD_W        54
`define SBT_IDX_W         15
`define SBT_SEL_W         3
`define SBT_NREG          8

// store-back codes
`define SBT_SB_LEAD_FAST  3'h0
`define SBT_SB_EXT_FAST   3'h1
`define SBT_SB_IDX_INC    3'h2
`define SBT_SB_IDX_STEP   3'h3
`define SBT_SB_LEAD_IDX   3'h4
`define SBT_SB_EXT_IDX    3'h5
`define SBT_SB_IDX_DEC    3'h6
`define SBT_SB_ADDR_IDX   3'h7

// sense-light test codes in the third operation field
`define SBT_TEST_LIGHTS_ON  3'h3
`define SBT_TEST_LIGHTS_OFF 3'h7

`define SBT_CC_RESET      15'h0000
`define SBT_IDX_ONE       15'h0001
`define SBT_CC_SKIP       15'h0002
`define SBT_LIGHTS_NONE   15'h0000

`endif

// file: sbt_pkg.sv
// types for the store-back and test-branch block
package sbt_pkg;

  typedef enum logic [1:0] {
    SBT_ST_IDLE  = 2'b00,
    SBT_ST_EXEC  = 2'b01,
    SBT_ST_STORE = 2'b10,
    SBT_ST_HALT  = 2'b11
  } sbt_state_t;

  typedef enum logic [1:0] {
    SBT_BR_NONE  = 2'b00,
    SBT_BR_SKIP  = 2'b01,
    SBT_BR_JUMP  = 2'b10
  } sbt_branch_t;

endpackage : sbt_pkg

// file: sbt_regfile.sv
// fast-store group and index group registers
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_regfile (
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic                    wr_fast,
  input  wire logic                    wr_idx,
  input  wire logic [`SBT_SEL_W-1:0]   wr_sel,
  input  wire logic [`SBT_WORD_W-1:0]  wr_fast_data,
  input  wire logic [`SBT_IDX_W-1:0]   wr_idx_data,
  input  wire logic [`SBT_SEL_W-1:0]   rd_sel,
  output logic      [`SBT_WORD_W-1:0]  rd_fast,
  output logic      [`SBT_IDX_W-1:0]   rd_idx
);

  typedef struct packed {
    logic [`SBT_NREG-1:0][`SBT_WORD_W-1:0] fast;
    logic [`SBT_NREG-1:0][`SBT_IDX_W-1:0]  idx;
  } sbt_rf_t;

  sbt_rf_t rf_ff;
  sbt_rf_t nxt_rf;

  always_comb begin
    nxt_rf = rf_ff;
    for (int i = 0; i < `SBT_NREG; i++) begin
      if (wr_fast && (wr_sel == i[`SBT_SEL_W-1:0])) begin
        nxt_rf.fast[i] = wr_fast_data;
      end
      if (wr_idx && (wr_sel == i[`SBT_SEL_W-1:0])) begin
        nxt_rf.idx[i] = wr_idx_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rf_ff <= '0;
    end else begin
      rf_ff <= nxt_rf;
    end
  end

  assign rd_fast = rf_ff.fast[rd_sel];
  assign rd_idx  = rf_ff.idx[rd_sel];

endmodule : sbt_regfile

// file: sbt_top.sv
// store-back stage and conditional skip, jump and halt sequencing
//
// Notes on behaviour
// RULE_01: the target-select field is an octal register number naming a fast or an index register.
// RULE_02: store-back code 0 writes the whole lead operand word into the chosen fast register.
// RULE_03: store-back code 1 writes the whole extension word into the chosen fast register.
// RULE_04: store-back code 2 adds one to the chosen index register.
// RULE_05: store-back code 3 adds the step amount to the chosen index register.
// RULE_06: store-back code 4 copies the low 15 bits of the lead operand into the index register.
// RULE_07: store-back code 5 copies the low 15 bits of the extension word into the index register.
// RULE_08: store-back code 6 subtracts one from the chosen index register.
// RULE_09: store-back code 7 copies the order's address part into the chosen index register.
// RULE_10: light-test codes 3 and 7 use the address part as the light mask, with skip or jump only.
// RULE_11: a satisfied jump adds the step amount to the control counter, else it advances by one.
// RULE_12: a satisfied skip advances the counter by two, else by one.
// RULE_13: the store-back step is done whether or not the test is satisfied.
// RULE_14: the halt order stops with the order held visible until continue is pressed.
// RULE_15: the store-back write happens only after the main operation stage has finished.
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_top (
  input  wire logic                    mclk,
  input  wire logic                    srst,
  // order issue
  input  wire logic                    order_valid,
  output logic                         order_ready,
  input  wire logic [2:0]              order_sb_code,
  input  wire logic [`SBT_SEL_W-1:0]   order_target,
  input  wire logic [2:0]              order_test_code,
  input  wire sbt_pkg::sbt_branch_t    order_branch,
  input  wire logic [`SBT_IDX_W-1:0]   order_addr,
  input  wire logic                    order_halt,
  // arithmetic side
  input  wire logic                    main_done,
  input  wire logic                    cond_ok,
  input  wire logic [`SBT_WORD_W-1:0]  lead_word,
  input  wire logic [`SBT_WORD_W-1:0]  ext_word,
  input  wire logic [`SBT_IDX_W-1:0]   step_amount,
  input  wire logic [`SBT_IDX_W-1:0]   sense_lights,
  // operator console
  input  wire logic                    continue_press,
  // status and register views
  output logic      [`SBT_IDX_W-1:0]   control_counter,
  output logic      [`SBT_IDX_W-1:0]   held_addr,
  output logic                         order_done,
  output logic                         halted,
  input  wire logic [`SBT_SEL_W-1:0]   peek_sel,
  output logic      [`SBT_WORD_W-1:0]  peek_fast,
  output logic      [`SBT_IDX_W-1:0]   peek_idx
);

  // ==========================================================
  // state
  typedef struct packed {
    sbt_pkg::sbt_state_t   state;
    logic [`SBT_IDX_W-1:0] cc;
    logic [2:0]            code;
    logic [`SBT_SEL_W-1:0] target;
    logic [2:0]            test;
    sbt_pkg::sbt_branch_t  branch;
    logic [`SBT_IDX_W-1:0] addr;
    logic                  done;
  } sbt_top_st_t;

  sbt_top_st_t st_ff;
  sbt_top_st_t nxt_st;

  logic                   wr_fast;
  logic                   wr_idx;
  logic [`SBT_WORD_W-1:0] wr_fast_data;
  logic [`SBT_IDX_W-1:0]  wr_idx_data;
  logic [`SBT_IDX_W-1:0]  idx_cur;
  logic                   test_pass;
  logic                   light_test;
  logic [`SBT_IDX_W-1:0]  lit;
  logic [`SBT_SEL_W-1:0]  rd_sel;

  // ==========================================================
  // registers addressed by the target field
  sbt_regfile u_rf (
    .mclk         (mclk),
    .srst         (srst),
    .wr_fast      (wr_fast),
    .wr_idx       (wr_idx),
    .wr_sel       (st_ff.target),
    .wr_fast_data (wr_fast_data),
    .wr_idx_data  (wr_idx_data),
    .rd_sel       (rd_sel),
    .rd_fast      (peek_fast),
    .rd_idx       (idx_cur)
  );

  // the store stage owns the single read port, so a peek during that cycle
  // shows the order's target; this saves a second wide eight-way mux
  assign rd_sel = (st_ff.state == sbt_pkg::SBT_ST_STORE) ? st_ff.target : peek_sel;

  // ==========================================================
  // store-back decode
  always_comb begin
    wr_fast      = 1'b0;
    wr_idx       = 1'b0;
    wr_fast_data = lead_word;
    wr_idx_data  = idx_cur;
    if (st_ff.state == sbt_pkg::SBT_ST_STORE) begin // RULE_15 RULE_13
      case (st_ff.code) // RULE_01
        `SBT_SB_LEAD_FAST: begin
          wr_fast      = 1'b1;
          wr_fast_data = lead_word; // RULE_02
        end
        `SBT_SB_EXT_FAST: begin
          wr_fast      = 1'b1;
          wr_fast_data = ext_word; // RULE_03
        end
        `SBT_SB_IDX_INC: begin
          wr_idx      = 1'b1;
          wr_idx_data = idx_cur + `SBT_IDX_ONE; // RULE_04
        end
        `SBT_SB_IDX_STEP: begin
          wr_idx      = 1'b1;
          wr_idx_data = idx_cur + step_amount; // RULE_05
        end
        `SBT_SB_LEAD_IDX: begin
          wr_idx      = 1'b1;
          wr_idx_data = lead_word[`SBT_IDX_W-1:0]; // RULE_06
        end
        `SBT_SB_EXT_IDX: begin
          wr_idx      = 1'b1;
          wr_idx_data = ext_word[`SBT_IDX_W-1:0]; // RULE_07
        end
        `SBT_SB_IDX_DEC: begin
          wr_idx      = 1'b1;
          wr_idx_data = idx_cur - `SBT_IDX_ONE; // RULE_08
        end
        default: begin
          wr_idx      = 1'b1;
          wr_idx_data = st_ff.addr; // RULE_09
        end
      endcase
    end
  end

  // ==========================================================
  // condition: light tests use the address part as mask
  always_comb begin
    lit        = sense_lights & st_ff.addr;
    light_test = (st_ff.test == `SBT_TEST_LIGHTS_ON) ||
                 (st_ff.test == `SBT_TEST_LIGHTS_OFF);
    if (!light_test) begin
      test_pass = cond_ok;
    end else if (st_ff.test == `SBT_TEST_LIGHTS_ON) begin
      test_pass = (lit == st_ff.addr); // RULE_10
    end else begin
      test_pass = (lit == `SBT_LIGHTS_NONE); // RULE_10
    end
  end

  // ==========================================================
  // sequencing
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.state)
      sbt_pkg::SBT_ST_IDLE: begin
        if (order_valid) begin
          nxt_st.code   = order_sb_code;
          nxt_st.target = order_target;
          nxt_st.test   = order_test_code;
          nxt_st.branch = order_branch;
          nxt_st.addr   = order_addr;
          if (order_halt) begin
            nxt_st.state = sbt_pkg::SBT_ST_HALT; // RULE_14
          end else begin
            nxt_st.state = sbt_pkg::SBT_ST_EXEC;
          end
        end
      end
      sbt_pkg::SBT_ST_EXEC: begin
        if (main_done) begin
          nxt_st.state = sbt_pkg::SBT_ST_STORE; // RULE_15
        end
      end
      sbt_pkg::SBT_ST_STORE: begin
        // light tests allow only skip or jump; a plain order just advances
        if ((st_ff.branch == sbt_pkg::SBT_BR_JUMP) && test_pass) begin
          nxt_st.cc = st_ff.cc + step_amount; // RULE_11
        end else if ((st_ff.branch == sbt_pkg::SBT_BR_SKIP) && test_pass) begin
          nxt_st.cc = st_ff.cc + `SBT_CC_SKIP; // RULE_12
        end else begin
          nxt_st.cc = st_ff.cc + `SBT_IDX_ONE; // RULE_11 RULE_12
        end
        nxt_st.done  = 1'b1;
        nxt_st.state = sbt_pkg::SBT_ST_IDLE;
      end
      default: begin
        // halted: order fields stay frozen for the console
        if (continue_press) begin
          nxt_st.cc    = st_ff.cc + `SBT_IDX_ONE; // RULE_14
          nxt_st.done  = 1'b1;
          nxt_st.state = sbt_pkg::SBT_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff.state  <= sbt_pkg::SBT_ST_IDLE;
      st_ff.cc     <= `SBT_CC_RESET;
      st_ff.code   <= 3'h0;
      st_ff.target <= 3'h0;
      st_ff.test   <= 3'h0;
      st_ff.branch <= sbt_pkg::SBT_BR_NONE;
      st_ff.addr   <= 15'h0000;
      st_ff.done   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign order_ready     = (st_ff.state == sbt_pkg::SBT_ST_IDLE);
  assign control_counter = st_ff.cc;
  assign held_addr       = st_ff.addr;
  assign peek_idx        = idx_cur;
  assign order_done      = st_ff.done;
  assign halted          = (st_ff.state == sbt_pkg::SBT_ST_HALT); // RULE_14

endmodule : sbt_top

// file: sbt_top_bench.sv
// self-checking bench for the store-back and test-branch block
`timescale 1ns/1ps
`include "sbt_consts.svh"

module sbt_top_bench;
  logic                   mclk, srst, order_valid, order_ready, order_halt;
  logic                   main_done, cond_ok, continue_press, order_done, halted;
  logic [2:0]             order_sb_code, order_target, order_test_code, peek_sel;
  sbt_pkg::sbt_branch_t   order_branch;
  logic [`SBT_IDX_W-1:0]  order_addr, step_amount, sense_lights;
  logic [`SBT_IDX_W-1:0]  control_counter, held_addr, exp_cc;
  logic [`SBT_WORD_W-1:0] lead_word, ext_word, peek_fast;
  logic [`SBT_IDX_W-1:0]  peek_idx;
  logic [`SBT_WORD_W-1:0] exp_fast [8];
  logic [`SBT_IDX_W-1:0]  exp_idx [8];
  int                     n_errors, samples_checked, cycles;
  localparam sbt_pkg::sbt_branch_t br_no = sbt_pkg::SBT_BR_NONE;
  localparam sbt_pkg::sbt_branch_t br_sk = sbt_pkg::SBT_BR_SKIP;
  localparam sbt_pkg::sbt_branch_t br_jp = sbt_pkg::SBT_BR_JUMP;

  sbt_top dut_u (.mclk, .srst, .order_valid, .order_ready, .order_sb_code, .order_target,
    .order_test_code, .order_branch, .order_addr, .order_halt, .main_done, .cond_ok,
    .lead_word, .ext_word, .step_amount, .sense_lights, .continue_press, .control_counter,
    .held_addr, .order_done, .halted, .peek_sel, .peek_fast, .peek_idx);

  always #4 mclk = ~mclk;

  // ==========================================================
  // compare and closing tasks
  task automatic chk15(string nm, logic [14:0] e, logic [14:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk15

  task automatic chk1(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask : chk1

  task automatic chk54(string nm, logic [`SBT_WORD_W-1:0] e, logic [`SBT_WORD_W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk54

  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // hang guard; the whole run needs under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  // ==========================================================
  // scenarios; each starts at a falling edge with the block idle
  task automatic run(logic [2:0] sb, tc, sbt_pkg::sbt_branch_t br,
                     logic [14:0] ad, x, lt, logic ok, int hold, logic [14:0] dcc);
    logic [2:0] t;
    t = ~sb;
    order_valid = 1'b1;
    order_sb_code = sb;
    order_target = t;
    peek_sel = t;
    order_test_code = tc;
    order_branch = br;
    order_addr = ad;
    step_amount = x;
    sense_lights = lt;
    cond_ok = ok;
    // low halves differ from the address so code 4, 5 and 7 cannot stand in for each other
    lead_word = {24'h5a_5a5a, ad, x};
    ext_word = {24'ha5_a5a5, x, ~ad};
    @(negedge mclk);
    order_valid = 1'b0;
    repeat (hold) begin
      chk1("ready", 1'b0, order_ready);
      @(negedge mclk);
    end
    main_done = 1'b1;
    @(negedge mclk);
    main_done = 1'b0;
    chk1("done", 1'b0, order_done);
    @(negedge mclk);
    exp_cc = exp_cc + dcc;
    chk1("done", 1'b1, order_done);
    chk15("cc", exp_cc, control_counter);
    case (sb)
      `SBT_SB_LEAD_FAST: exp_fast[t] = lead_word;
      `SBT_SB_EXT_FAST:  exp_fast[t] = ext_word;
      `SBT_SB_IDX_INC:   exp_idx[t] = exp_idx[t] + 15'h0001;
      `SBT_SB_IDX_STEP:  exp_idx[t] = exp_idx[t] + x;
      `SBT_SB_LEAD_IDX:  exp_idx[t] = lead_word[`SBT_IDX_W-1:0];
      `SBT_SB_EXT_IDX:   exp_idx[t] = ext_word[`SBT_IDX_W-1:0];
      `SBT_SB_IDX_DEC:   exp_idx[t] = exp_idx[t] - 15'h0001;
      `SBT_SB_ADDR_IDX:  exp_idx[t] = ad;
    endcase
    chk54("fast", exp_fast[t], peek_fast);
    chk15("idx", exp_idx[t], peek_idx);
  endtask : run

  task automatic t_halt();
    order_halt = 1'b1;
    order_valid = 1'b1;
    order_addr = 15'h5b6d;
    @(negedge mclk);
    order_valid = 1'b0;
    order_halt = 1'b0;
    repeat (4) begin
      chk1("halted", 1'b1, halted);
      chk15("held", 15'h5b6d, held_addr);
      @(negedge mclk);
    end
    continue_press = 1'b1;
    @(negedge mclk);
    continue_press = 1'b0;
    exp_cc = exp_cc + 15'h0001;
    chk1("halted", 1'b0, halted);
    chk1("done", 1'b1, order_done);
    chk15("cc", exp_cc, control_counter);
  endtask : t_halt

  // reset in mid-run must clear the counter, the order holder and all registers
  task automatic t_reset();
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    exp_cc = 15'h0000;
    for (int i = 0; i < 8; i++) begin
      exp_fast[i] = '0;
      exp_idx[i] = '0;
    end
    chk15("cc", 15'h0000, control_counter);
    chk15("held", 15'h0000, held_addr);
    chk1("done", 1'b0, order_done);
    chk1("ready", 1'b1, order_ready);
    chk1("halted", 1'b0, halted);
    for (int i = 0; i < 8; i++) begin
      peek_sel = 3'(i);
      @(negedge mclk);
      chk54("fast", 54'h0, peek_fast);
      chk15("idx", 15'h0000, peek_idx);
    end
  endtask : t_reset

  initial begin
    {mclk, srst, order_valid, order_halt, main_done, cond_ok, continue_press} = 7'h00;
    {order_sb_code, order_target, order_test_code, peek_sel} = 12'h000;
    {order_addr, step_amount, sense_lights} = 45'h0;
    {lead_word, ext_word} = 108'h0;
    order_branch = br_no;
    exp_cc = 15'h0000;
    for (int i = 0; i < 8; i++) begin
      exp_fast[i] = '0;
      exp_idx[i] = '0;
    end
    srst = 1'b1;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    chk15("cc", 15'h0000, control_counter);
    chk1("ready", 1'b1, order_ready);
    chk1("halted", 1'b0, halted);
    // every store-back code, back to back, some with a slow main stage
    for (int c = 0; c < 8; c++)
      run(3'(c), 3'h0, br_no, 15'h1234, 15'h0010, 15'h0, 1'b1, c % 3, 15'h0001);
    run(3'h2, 3'h0, br_jp, 15'h0000, 15'h0100, 15'h0, 1'b1, 0, 15'h0100);
    run(3'h6, 3'h0, br_jp, 15'h0000, 15'h0100, 15'h0, 1'b0, 0, 15'h0001);
    run(3'h3, 3'h0, br_jp, 15'h0000, 15'h7ffe, 15'h0, 1'b1, 1, 15'h7ffe);
    run(3'h2, 3'h0, br_sk, 15'h0000, 15'h0040, 15'h0, 1'b1, 0, 15'h0002);
    run(3'h2, 3'h0, br_sk, 15'h0000, 15'h0040, 15'h0, 1'b0, 0, 15'h0001);
    // light tests must ignore cond_ok and use the address as mask
    run(3'h7, 3'h3, br_sk, 15'h3002, 15'h0040, 15'h7003, 1'b0, 0, 15'h0002);
    run(3'h7, 3'h3, br_sk, 15'h3002, 15'h0040, 15'h3000, 1'b1, 0, 15'h0001);
    run(3'h4, 3'h7, br_jp, 15'h0101, 15'h0040, 15'h7cfe, 1'b0, 0, 15'h0040);
    run(3'h5, 3'h7, br_jp, 15'h0101, 15'h0040, 15'h0001, 1'b1, 0, 15'h0001);
    t_halt();
    t_reset();
    run(3'h3, 3'h0, br_jp, 15'h0000, 15'h0005, 15'h0, 1'b1, 0, 15'h0005);
    close_out();
  end
endmodule : sbt_top_bench
